//--- sar_adc_conversion_serial_readout_tb.sv
// Self-checking bench of the converter control and serial readout
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sar_adc_conversion_serial_readout_tb;
  import sar_adc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rc_n = 1'b1;
  logic cs_n = 1'b1;
  logic sel = 1'b0;
  logic pd = 1'b0;
  logic sync_en = 1'b0;
  logic comp, bclk_host, daisy, bclk_o, bclk_oe, sdata, sync_o, busy_n, pin, d, s, dz;
  logic [RESULT_W-1:0] dac, v, w;
  logic [15:0] hist[$];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int busy_cyc = 0;

  always #2 clk = ~clk;
  assign pin = bclk_oe ? bclk_o : bclk_host;

  sar_adc_core i_dut (.CLK_I(clk), .RST_I(rst), .RD_CONV_N_I(rc_n), .CHIP_SEL_N_I(cs_n),
    .CLOCK_SOURCE_SELECT_I(sel), .POWER_DOWN_INPUT_I(pd), .SYNC_EN_I(sync_en),
    .DAISY_I(daisy), .COMP_I(comp), .SERIAL_BIT_CLOCK_I(bclk_host),
    .SERIAL_BIT_CLOCK_O(bclk_o), .SERIAL_BIT_CLOCK_OE_O(bclk_oe), .SDATA_O(sdata),
    .SYNC_O(sync_o), .BUSY_N_O(busy_n), .DAC_CODE_O(dac));

  sar_host_model i_host (.dac_i(dac), .sdata_i(sdata), .sync_i(sync_o), .pin_i(pin),
    .int_mode_i(bclk_oe), .comp_o(comp), .bclk_o(bclk_host), .daisy_o(daisy));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Chip select falls first, read/convert three cycles later and held low 80 ns
  task automatic convert(input logic [15:0] val, input logic starts);
    i_host.vin = val;
    cs_n = 1'b0;
    cyc(3);
    rc_n = 1'b0;
    cyc(20);
    `CHK(busy_n, ~starts)
    rc_n = 1'b1;
  endtask : convert

  task automatic wait_done();
    int t;
    t = 0;
    while (busy_n !== 1'b1 && t < 3000) begin
      cyc(1);
      t++;
    end
    `CHK(busy_n, 1'b1)
    `CHK(busy_cyc >= CONV_MIN_CYC, 1'b1)
  endtask : wait_done

  task automatic tally_and_finish();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Cut a hang short; the whole run needs about 10600 cycles
  always @(posedge clk) begin
    cycles++;
    // Length of the current busy-low stretch in clock cycles
    busy_cyc = (busy_n === 1'b0) ? busy_cyc + 1 : 0;
    if (cycles == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    void'($urandom(82));
    cyc(6);
    `CHK(busy_n, 1'b1)
    `CHK(bclk_o, 1'b0)
    rst = 1'b0;
    sel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      dz = 1'($urandom);
      i_host.daisy_o = dz;
      i_host.npulse = 0;
      i_host.unstable = 0;
      convert(v, 1'b1);
      wait_done();
      // The word shifted during the first conversion is meaningless
      if (i > 0) begin
        `CHK(i_host.iword, hist[$])
        `CHK(i_host.npulse, 16)
        `CHK(i_host.unstable, 0)
        `CHK(sdata, dz)
        `CHK(bclk_o, 1'b0)
      end
      hist.push_back(v);
    end
    $display("test internal_clock done");
    pd = 1'b1;
    cyc(4);
    convert(16'h1234, 1'b0);
    pd = 1'b0;
    cs_n = 1'b1;
    cyc(4);
    cs_n = 1'b0;
    cyc(3);
    rc_n = 1'b0;
    cyc(8);
    rc_n = 1'b1;
    cyc(20);
    `CHK(busy_n, 1'b1)
    $display("test refusals done");
    sel = 1'b1;
    cyc(4);
    v = 16'($urandom);
    convert(v, 1'b1);
    wait_done();
    hist.push_back(v);
    dz = 1'($urandom);
    #1.3;
    i_host.ext_read(18, 0, dz, w, d, s);
    `CHK(w, hist[$])
    `CHK(d, dz)
    `CHK(s, 1'b0)
    cyc(4);
    v = 16'($urandom);
    convert(v, 1'b1);
    cyc(4);
    i_host.ext_read(17, 0, ~dz, w, d, s);
    `CHK(w, hist[$])
    `CHK(d, ~dz)
    wait_done();
    hist.push_back(v);
    $display("test external_no_marker done");
    sync_en = 1'b1;
    cs_n = 1'b1;
    cyc(3);
    i_host.ext_read(1, 0, 1'b0, w, d, s);
    cyc(3);
    cs_n = 1'b0;
    cyc(3);
    i_host.ext_read(19, 1, dz, w, d, s);
    `CHK(s, 1'b1)
    `CHK(w, hist[$])
    `CHK(d, dz)
    $display("test external_marker done");
    tally_and_finish();
  end
endmodule : sar_adc_conversion_serial_readout_tb

//--- sar_adc_core.sv
// Conversion control, SAR sequencing and serial result readout of a 16-bit converter
//
// Contract
// - Host holds read/convert low with chip select low 50 ns; conversion then starts.
// - Busy stays low from conversion start until result latched, then tracking resumes.
// - Read/convert and chip select are ORed; host keeps 10 ns between falls.
// - First conversion after power-up outputs meaningless serial bits.
// - Internal mode shifts previous 16-bit result MSB first with 16 clock pulses.
// - Internal mode holds each bit stable across both edges of its pulse.
// - Internal mode shows sampled daisy level after LSB; clock stays low.
// - External mode reads previous result during or current result after conversion.
// - Frame marker optional with discontinuous clock, forced with continuous clock; here it needs clock edges outside a read and SYNC_EN_I high.
// - External bit valid from one falling edge to next rising edge.
// - After-conversion read waits busy high, then chip select low, read/convert high.
// - No marker: MSB on falling 1/rising 2, LSB on falling 16/rising 17.
// - After rising edge 17 data shows daisy level sampled on first rising edge.
// - During-conversion read waits busy low, then chip select low, read/convert high.
// - Correction step can reverse a wrong decision of the first conversion half.
// - Read/convert rising with chip select low enables serial transmission.
// - Power-down inhibits conversions and keeps the previous result.
`timescale 1ns/1ps
module sar_adc_core (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic RD_CONV_N_I,
  input wire logic CHIP_SEL_N_I,
  input wire logic CLOCK_SOURCE_SELECT_I,
  input wire logic POWER_DOWN_INPUT_I,
  input wire logic SYNC_EN_I,
  input wire logic DAISY_I,
  input wire logic COMP_I,
  input wire logic SERIAL_BIT_CLOCK_I,
  output logic SERIAL_BIT_CLOCK_O,
  output logic SERIAL_BIT_CLOCK_OE_O,
  output logic SDATA_O,
  output logic SYNC_O,
  output logic BUSY_N_O,
  output logic [sar_adc_pkg::RESULT_W-1:0] DAC_CODE_O
);
  import sar_adc_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [PIN_W-1:0] pin_s;
  logic rc_s, cs_s, sel_s, power_down_input_s, daisy_s, comp_s;
  logic frame_active, frame_busy_s;
  logic both_low;

  sar_sync2 #(.W(PIN_W), .RST_VAL(PIN_IDLE)) u_pin_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i({RD_CONV_N_I, CHIP_SEL_N_I, CLOCK_SOURCE_SELECT_I, POWER_DOWN_INPUT_I,
          DAISY_I, COMP_I}),
    .q_o(pin_s)
  );

  sar_sync2 #(.W(1), .RST_VAL(1'h0)) u_frame_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(frame_active),
    .q_o(frame_busy_s)
  );

  assign {rc_s, cs_s, sel_s, power_down_input_s, daisy_s, comp_s} = pin_s;
  // Conversion request is the OR of both pins, so either may fall first
  assign both_low = ~(rc_s | cs_s);

  // ==========================================================================
  // Conversion sequencer
  // ==========================================================================
  conv_e state, next_state;
  logic [CNT_W-1:0] low_cnt, next_low_cnt, step_cnt, next_step_cnt;
  logic [IDX_W-1:0] idx, next_idx;
  logic [RESULT_W-1:0] code, next_code, result, next_result, dac, next_dac;
  logic busy_n, next_busy_n;
  logic start_conv;

  // Trial weight per step; the correction step adds no new bit
  function automatic logic [RESULT_W-1:0] trial_bit(input logic [IDX_W-1:0] i);
    logic [RESULT_W-1:0] b;
    b = '0;
    if (i < CORR_IDX) begin
      b = MSB_ONE >> i;
    end else if (i > CORR_IDX) begin
      b = MSB_ONE >> (i - 5'h01);
    end
    return b;
  endfunction : trial_bit

  // Fires once on the cycle the low level reaches the least hold time
  assign start_conv = both_low && (low_cnt == HOLD_LAST) && (state == CONV_TRACK)
                      && !power_down_input_s;

  always_comb begin
    next_state = state;
    next_step_cnt = step_cnt;
    next_idx = idx;
    next_code = code;
    next_result = result;
    next_busy_n = busy_n;
    if (!both_low) begin
      next_low_cnt = '0;
    end else if (low_cnt == HOLD_SAT) begin
      next_low_cnt = low_cnt;
    end else begin
      next_low_cnt = low_cnt + 8'h01;
    end
    case (state)
      CONV_TRACK: begin
        if (start_conv) begin
          next_state = CONV_RUN;
          next_step_cnt = '0;
          next_idx = '0;
          next_code = '0;
          next_busy_n = 1'h0;
        end
      end
      CONV_RUN: begin
        next_step_cnt = step_cnt + 8'h01;
        if (step_cnt == STEP_LAST) begin
          next_step_cnt = '0;
          if (idx == CORR_IDX) begin
            // Input below the upper-half code means an upper decision was too high
            if (!comp_s && (code != '0)) begin
              next_code = code - CORR_WEIGHT;
            end
          end else if (comp_s) begin
            next_code = code | trial_bit(idx);
          end
          if (idx == LAST_IDX) begin
            next_state = CONV_LATCH;
          end else begin
            next_idx = idx + 5'h01;
          end
        end
      end
      CONV_LATCH: begin
        // A running external frame keeps its word; busy waits for it to finish
        if (!frame_busy_s) begin
          next_result = code;
          next_state = CONV_TRACK;
          next_busy_n = 1'h1;
        end
      end
      default: begin
        next_state = CONV_TRACK;
        next_busy_n = 1'h1;
      end
    endcase
    next_dac = (next_state == CONV_RUN) ? (next_code | trial_bit(next_idx)) : next_code;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= CONV_TRACK;
      low_cnt <= '0;
      step_cnt <= '0;
      idx <= '0;
      code <= '0;
      // No conversion precedes the first, so its serial word carries no data
      result <= '0;
      dac <= '0;
      busy_n <= 1'h1;
    end else begin
      state <= next_state;
      low_cnt <= next_low_cnt;
      step_cnt <= next_step_cnt;
      idx <= next_idx;
      code <= next_code;
      result <= next_result;
      dac <= next_dac;
      busy_n <= next_busy_n;
    end
  end

  // ==========================================================================
  // Internal bit clock readout
  // ==========================================================================
  logic ser_active, next_ser_active;
  logic [IDX_W-1:0] ser_cnt, next_ser_cnt;
  logic [CNT_W-1:0] ph_cnt, next_ph_cnt;
  logic [RESULT_W-1:0] shreg, next_shreg;
  logic sclk_int, next_sclk_int, sdata_int, next_sdata_int, tag_int, next_tag_int;

  always_comb begin
    next_ser_active = ser_active;
    next_ser_cnt = ser_cnt;
    next_ph_cnt = ph_cnt;
    next_shreg = shreg;
    next_sclk_int = sclk_int;
    next_sdata_int = sdata_int;
    next_tag_int = tag_int;
    if (start_conv && !sel_s) begin
      // Word of the previous conversion goes out while this one runs
      next_ser_active = 1'h1;
      next_ser_cnt = '0;
      next_ph_cnt = '0;
      next_shreg = result;
      next_sdata_int = result[LAST_BIT];
      next_sclk_int = 1'h0;
      next_tag_int = daisy_s;
    end else if (ser_active) begin
      next_ph_cnt = ph_cnt + 8'h01;
      // Data moves mid low phase, so it is settled at both clock edges
      if ((ph_cnt == QUARTER_PH) && (ser_cnt == LAST_IDX)) begin
        // Tail waits a quarter period so the last falling edge still sees the LSB
        next_ser_active = 1'h0;
        next_sdata_int = tag_int;
      end else if ((ph_cnt == QUARTER_PH) && (ser_cnt != '0)) begin
        next_sdata_int = shreg[LAST_BIT];
      end
      if ((ph_cnt == HALF_LAST) && (ser_cnt != LAST_IDX)) begin
        next_sclk_int = 1'h1;
      end
      if (ph_cnt == PERIOD_LAST) begin
        next_sclk_int = 1'h0;
        next_ph_cnt = '0;
        next_shreg = shreg << 1;
        next_ser_cnt = ser_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ser_active <= 1'h0;
      ser_cnt <= '0;
      ph_cnt <= '0;
      shreg <= '0;
      sclk_int <= 1'h0;
      sdata_int <= 1'h0;
      tag_int <= 1'h0;
    end else begin
      ser_active <= next_ser_active;
      ser_cnt <= next_ser_cnt;
      ph_cnt <= next_ph_cnt;
      shreg <= next_shreg;
      sclk_int <= next_sclk_int;
      sdata_int <= next_sdata_int;
      tag_int <= next_tag_int;
    end
  end

  // ==========================================================================
  // External bit clock readout (link domain)
  // ==========================================================================
  // The host times chip select and read/convert to its own clock, so the link
  // logic samples them directly. Leaving the read state ends the frame at once,
  // which matters because a discontinuous clock gives no edge to end it.
  logic rd_en, frm_rst;
  logic arm, next_arm, use_sync, next_use_sync, us;
  logic sync_out, next_sync_out, sdata_ext, next_sdata_ext, tag_ext, next_tag_ext;
  logic next_frame_active;
  logic [EDGE_W-1:0] edge_cnt, next_edge_cnt, k, first;
  logic [RESULT_W-1:0] shx, next_shx, src, ld_word;

  assign rd_en = ~CHIP_SEL_N_I & RD_CONV_N_I;
  assign frm_rst = RST_I | ~rd_en;

  // Clock activity outside a read arms the frame marker
  assign next_arm = rd_en ? ((edge_cnt == '0) ? 1'h0 : arm) : 1'h1;

  always_ff @(posedge SERIAL_BIT_CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      arm <= 1'h0;
    end else begin
      arm <= next_arm;
    end
  end

  always_comb begin
    k = edge_cnt + 5'h01;
    us = (edge_cnt == '0) ? (arm & SYNC_EN_I) : use_sync;
    first = us ? FIRST_SYNC : FIRST_NOSYNC;
    // The result word is quiet at the first edge: it moves only at conversion end
    src = (edge_cnt == '0) ? result : shx;
    next_use_sync = us;
    next_shx = src;
    next_sdata_ext = sdata_ext;
    next_tag_ext = tag_ext;
    next_sync_out = (k == FIRST_NOSYNC) && us;
    next_edge_cnt = (edge_cnt < first + FRAME_BITS) ? k : edge_cnt;
    if (k == first) begin
      next_tag_ext = DAISY_I;
    end
    // A bit changes on a rising edge, valid from that falling to the next rising
    if ((k >= first) && (k < first + FRAME_BITS)) begin
      next_sdata_ext = src[LAST_BIT];
      next_shx = src << 1;
    end else if (k == first + FRAME_BITS) begin
      next_sdata_ext = tag_ext;
    end
    next_frame_active = (next_edge_cnt < first + LSB_OFF);
  end

  always_ff @(posedge SERIAL_BIT_CLOCK_I or posedge frm_rst) begin
    if (frm_rst) begin
      edge_cnt <= '0;
      use_sync <= 1'h0;
      shx <= '0;
      sdata_ext <= 1'h0;
      tag_ext <= 1'h0;
      sync_out <= 1'h0;
      frame_active <= 1'h0;
    end else begin
      edge_cnt <= next_edge_cnt;
      use_sync <= next_use_sync;
      shx <= next_shx;
      sdata_ext <= next_sdata_ext;
      tag_ext <= next_tag_ext;
      sync_out <= next_sync_out;
      frame_active <= next_frame_active;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign SERIAL_BIT_CLOCK_O = sclk_int;
  assign SERIAL_BIT_CLOCK_OE_O = ~sel_s;
  assign SDATA_O = sel_s ? sdata_ext : sdata_int;
  assign SYNC_O = sel_s & sync_out;
  assign BUSY_N_O = busy_n;
  assign DAC_CODE_O = dac;

  // ==========================================================================
  // Assertion helpers and assertions
  // ==========================================================================
  logic [LEN_W-1:0] conv_len;
  logic [IDX_W-1:0] pulse_cnt;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      conv_len <= '0;
      pulse_cnt <= '0;
    end else begin
      conv_len <= start_conv ? '0 : (busy_n ? conv_len : conv_len + 16'h0001);
      pulse_cnt <= (start_conv && !sel_s) ? '0 :
                   ((next_sclk_int && !sclk_int) ? pulse_cnt + 5'h01 : pulse_cnt);
    end
  end

  always_ff @(posedge SERIAL_BIT_CLOCK_I or posedge frm_rst) begin
    if (frm_rst) begin
      ld_word <= '0;
    end else if (edge_cnt == '0) begin
      ld_word <= result;
    end
  end

  a_busy_start: assert property (@(posedge CLK_I) disable iff (RST_I)
    start_conv |=> !BUSY_N_O ##1 !BUSY_N_O) else $error("busy not low after start");
  a_conv_time: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(BUSY_N_O) |-> conv_len >= LEN_W'(CONV_MIN_CYC)) else $error("conversion too short");
  a_hold_time: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(BUSY_N_O) |-> $past(both_low, 2) && $past(both_low, 13)) else $error("hold short");
  a_or_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!both_low && BUSY_N_O) |=> BUSY_N_O) else $error("start without both low");
  a_power_down_input_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    (power_down_input_s && BUSY_N_O) |=> BUSY_N_O && $stable(result)) else $error("power-down leak");
  a_int_pulses: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(ser_active) |-> pulse_cnt == 5'h10) else $error("internal pulse count wrong");
  a_int_stable: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(sdata_int) |-> !sclk_int && !$past(sclk_int)) else $error("data moved at edge");
  a_int_tail: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(ser_active) |-> sdata_int == tag_int ##1 !sclk_int) else $error("tail wrong");
  a_ext_msb_lsb: assert property (@(posedge SERIAL_BIT_CLOCK_I) disable iff (frm_rst)
    (edge_cnt == 5'h01 && !use_sync) |-> sdata_ext == ld_word[LAST_BIT]
    ##15 sdata_ext == ld_word[0]) else $error("external bit order wrong");
  a_ext_tag: assert property (@(posedge SERIAL_BIT_CLOCK_I) disable iff (frm_rst)
    (edge_cnt == 5'h11 && !use_sync) |-> sdata_ext == tag_ext) else $error("tag missing");
  a_sync_pulse: assert property (@(posedge SERIAL_BIT_CLOCK_I) disable iff (frm_rst)
    (edge_cnt == 5'h01 && use_sync) |-> sync_out ##1 !sync_out) else $error("marker wrong");

  c_conversion: cover property (@(posedge CLK_I) disable iff (RST_I) $rose(BUSY_N_O));
  c_int_read: cover property (@(posedge CLK_I) disable iff (RST_I) $fell(ser_active));
  c_ext_nosync: cover property (@(posedge SERIAL_BIT_CLOCK_I) disable iff (frm_rst)
    edge_cnt == 5'h11 && !use_sync);
  c_ext_sync: cover property (@(posedge SERIAL_BIT_CLOCK_I) disable iff (frm_rst)
    edge_cnt == 5'h12 && use_sync);
endmodule : sar_adc_core

//--- sar_adc_pkg.sv
// Shared constants, timing counts and state types of the SAR converter control block
package sar_adc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_HOLD_NS = 50;
  localparam int EDGE_GAP_NS = 10;
  localparam int STEP_NS = 400;
  localparam int BIT_HALF_NS = 40;

  // Least times round up, longest times round down, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  function automatic int max_cycles(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : max_cycles

  localparam int CONV_HOLD_CYC = min_cycles(CONV_HOLD_NS);
  localparam int EDGE_GAP_CYC = min_cycles(EDGE_GAP_NS);
  localparam int STEP_CYC = max_cycles(STEP_NS);
  localparam int HALF_CYC = max_cycles(BIT_HALF_NS);
  localparam int SAR_STEPS = 17;
  localparam int CONV_MIN_CYC = SAR_STEPS * STEP_CYC;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int RESULT_W = 16;
  localparam int LAST_BIT = RESULT_W - 1;
  localparam int CNT_W = 8;
  localparam int IDX_W = 5;
  localparam int EDGE_W = 5;
  localparam int LEN_W = 16;
  localparam int PIN_W = 6;

  // ==========================================================================
  // Typed compare values
  // ==========================================================================
  localparam logic [CNT_W-1:0] HOLD_SAT = CNT_W'(CONV_HOLD_CYC);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(CONV_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);
  localparam logic [CNT_W-1:0] QUARTER_PH = CNT_W'(HALF_CYC / 2);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(2 * HALF_CYC - 1);
  localparam logic [IDX_W-1:0] CORR_IDX = 5'h08;
  localparam logic [IDX_W-1:0] LAST_IDX = 5'h10;
  localparam logic [IDX_W-1:0] BIT_LAST = 5'h0f;
  localparam logic [EDGE_W-1:0] FIRST_NOSYNC = 5'h01;
  localparam logic [EDGE_W-1:0] FIRST_SYNC = 5'h02;
  localparam logic [EDGE_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [EDGE_W-1:0] LSB_OFF = 5'h0f;
  localparam logic [RESULT_W-1:0] MSB_ONE = 16'h8000;
  localparam logic [RESULT_W-1:0] CORR_WEIGHT = 16'h0100;
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h30;

  typedef enum logic [1:0] {CONV_TRACK, CONV_RUN, CONV_LATCH} conv_e;

endpackage : sar_adc_pkg

//--- sar_host_model.sv
// Host-side partner: analog source, external bit clock master and serial capture
`timescale 1ns/1ps
module sar_host_model (
  input wire logic [15:0] dac_i,
  input wire logic sdata_i,
  input wire logic sync_i,
  input wire logic pin_i,
  input wire logic int_mode_i,
  output logic comp_o,
  output logic bclk_o,
  output logic daisy_o
);
  logic [15:0] vin = 16'h0000;
  logic [15:0] iword = 16'h0000;
  logic rise_bit = 1'b0;
  int npulse = 0;
  int unstable = 0;

  // ==========================================================================
  // Analog side
  // ==========================================================================
  // Input sits half a step above vin, so the trial code equal to vin is kept
  assign comp_o = (vin >= dac_i);

  initial begin
    bclk_o = 1'b0;
    daisy_o = 1'b0;
  end

  // ==========================================================================
  // Internal clock capture: data must agree at both edges of each pulse
  // ==========================================================================
  always @(posedge pin_i) begin
    if (int_mode_i) rise_bit = sdata_i;
  end

  always @(negedge pin_i) begin
    if (int_mode_i) begin
      iword = {iword[14:0], sdata_i};
      npulse++;
      if (sdata_i !== rise_bit) unstable++;
    end
  end

  // ==========================================================================
  // External discontinuous clock: idles low and runs only while ext_read pulses it
  // ==========================================================================
  // Latches on falling edges; one pulse beyond the word shows the chained level
  task automatic ext_read(input int npl, input int mk, input logic dz,
                          output logic [15:0] w, output logic d, output logic s);
    w = 16'h0000;
    d = 1'b0;
    s = 1'b0;
    daisy_o = dz;
    // Tag level settles before rising edge 1 + mk samples it
    #2;
    for (int k = 1; k <= npl; k++) begin
      bclk_o = 1'b1;
      #7.5;
      bclk_o = 1'b0;
      if (k == 3 + mk) daisy_o = ~dz;
      // Without a marker s flags any pulse; with one, a single pulse at falling 1
      s = (k == 1) ? sync_i : ((mk != 0) ? (s & ~sync_i) : (s | sync_i));
      if (k > mk && k <= 16 + mk) w = {w[14:0], sdata_i};
      if (k == 17 + mk) d = sdata_i;
      #7.5;
    end
  endtask : ext_read
endmodule : sar_host_model

//--- sar_sync2.sv
// Two flip-flop level synchroniser with a constant reset value
`timescale 1ns/1ps
module sar_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : sar_sync2
